// ==== src/ppc_port_ctrl.sv ====
// port pin control: port 2 and 3 latches, analog select, shared reset pin, irq pins, axi slave
//
// Summary of operation
// - while reset is asserted the two oscillator-shared port 2 pins are pulled low.
// - option bit selects the shared reset pin as reset input or input port only.
// - the option is fetched only after reset release; a low reset pin before that holds reset.
// - a driven level change on either irq-shared pin in output mode sets its request flag.
// - an analog-select bit at 1 disables port function and routes that pin to the converter.
// - a single-bit port operation accesses the whole 8-bit port at once.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module ppc_port_ctrl
	import ppc_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// axi4-lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// option byte source and shared reset pin
	input  wire logic        optPortMode,
	input  wire logic        port3_bit4_reset_shared,
	// port pins
	input  wire logic [7:0]  p2PinIn,
	output logic [7:0]       p2PinOut,
	output logic [7:0]       p2PinOe,
	output logic [7:0]       p2PullUp,
	output logic [7:0]       p2PullDown,
	output logic [3:0]       analogRoute,
	input  wire logic [7:0]  p3PinIn,
	output logic [7:0]       p3PinOut,
	output logic [7:0]       p3PinOe,
	// system
	output logic             coreReset,
	output logic             irqOut
);
	////////////////////////////////////////////////////////////////////////////////
	// state
	logic [7:0] p2Lat_q, p2Lat_d, p2Mode_q, p2Mode_d, p2Pu_q, p2Pu_d, p3Lat_q, p3Lat_d;
	logic [7:0] p3Mode_q, p3Mode_d;
	logic [3:0] ana_q, ana_d;
	logic [1:0] stat_q, stat_d, mask_q, mask_d, drv_q, drv_d;
	logic       optPort_q, optPort_d;
	ppc_boot_t  boot_q, boot_d;
	logic       awHave_q, awHave_d, wHave_q, wHave_d, bValid_q, bValid_d, rValid_q, rValid_d;
	logic [7:0] awAddr_q, awAddr_d;
	logic [31:0] wData_q, wData_d, rData_q, rData_d;
	logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
	logic       irq_q, irq_d, coreRst_q, coreRst_d;
	logic [7:0] p2OutQ, p2OeQ, p2PuQ, p2PdQ, p3OutQ, p3OeQ;
	logic [7:0] p2Out_d, p2Oe_d, p2PuO_d, p2Pd_d, p3Out_d, p3Oe_d;
	logic [1:0] irqPinLvl;
	logic       wrFire;
	ppc_bit_if  bitIf();

	// read-modify-write merge for single-bit writes
	ppc_bit_merge uMerge
	(
		.bitIf (bitIf)
	);

	// pin level seen by software: latch for outputs, pin for inputs
	function automatic logic [7:0] pinImage(input logic [7:0] lat, input logic [7:0] mode,
		input logic [7:0] pins);
		pinImage = (lat & ~mode) | (pins & mode);
	endfunction

	assign bitIf.bitSel    = wData_q[2:0];
	assign bitIf.bitVal    = wData_q[POS_BIT_VAL];
	assign bitIf.pinLevels = wData_q[POS_BIT_PORT] ? pinImage(p3Lat_q, p3Mode_q, p3PinIn)
		: pinImage(p2Lat_q, p2Mode_q, p2PinIn);
	assign irqPinLvl = {p3OutQ[POS_IRQ_BIT2], p2OutQ[POS_IRQ_BIT1]};
	assign wrFire = awHave_q && wHave_q && !bValid_q;

	////////////////////////////////////////////////////////////////////////////////
	// next state: boot sequence, bus slave, registers, irq
	always_comb
	begin
		logic [1:0] outMode;
		logic [1:0] evt;
		outMode = {~p3Mode_q[POS_IRQ_BIT2], ~p2Mode_q[POS_IRQ_BIT1]};
		evt = outMode & (irqPinLvl ^ drv_q);
		boot_d = boot_q;
		optPort_d = optPort_q;
		coreRst_d = 1'b1;
		unique case (boot_q)
			BOOT_HOLD: boot_d = BOOT_FETCH;
			// a low shared pin stalls here, since the option is not known yet
			BOOT_FETCH:
			begin
				if (port3_bit4_reset_shared)
				begin
					optPort_d = optPortMode;
					boot_d = BOOT_RUN;
				end
			end
			BOOT_RUN:
			begin
				coreRst_d = 1'b0;
				if (!optPort_q && !port3_bit4_reset_shared)
					boot_d = BOOT_HOLD;
			end
			default: boot_d = BOOT_HOLD;
		endcase
		awHave_d = awHave_q; awAddr_d = awAddr_q; wHave_d = wHave_q; wData_d = wData_q;
		bValid_d = bValid_q; bResp_d = bResp_q; rValid_d = rValid_q; rData_d = rData_q;
		rResp_d = rResp_q;
		p2Lat_d = p2Lat_q; p2Mode_d = p2Mode_q; p2Pu_d = p2Pu_q; ana_d = ana_q;
		p3Lat_d = p3Lat_q; p3Mode_d = p3Mode_q; mask_d = mask_q;
		stat_d = stat_q;
		if (s_axi_awvalid && !awHave_q)
		begin
			awHave_d = 1'b1;
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHave_q)
		begin
			wHave_d = 1'b1;
			wData_d = s_axi_wdata;
		end
		if (bValid_q && s_axi_bready)
			bValid_d = 1'b0;
		if (wrFire)
		begin
			awHave_d = 1'b0;
			wHave_d = 1'b0;
			bValid_d = 1'b1;
			bResp_d = RESP_OKAY;
			unique case (awAddr_q)
				OFS_P2_LATCH:  p2Lat_d = wData_q[7:0];
				OFS_P2_MODE:   p2Mode_d = wData_q[7:0];
				OFS_P2_PULLUP: p2Pu_d = wData_q[7:0];
				OFS_ANA_SEL:   ana_d = wData_q[3:0];
				OFS_P3_LATCH:  p3Lat_d = wData_q[7:0];
				OFS_P3_MODE:   p3Mode_d = wData_q[7:0];
				OFS_BITOP:
				begin
					if (wData_q[POS_BIT_PORT])
						p3Lat_d = bitIf.merged;
					else
						p2Lat_d = bitIf.merged;
				end
				OFS_IRQ_STAT:  stat_d = stat_q & ~wData_q[1:0];
				OFS_IRQ_MASK:  mask_d = wData_q[1:0];
				OFS_P2_PINS, OFS_P3_PINS, OFS_OPTION: ;
				default:       bResp_d = RESP_SLVERR;
			endcase
		end
		// set wins over a write-one clear in the same cycle
		stat_d = stat_d | evt;
		if (rValid_q && s_axi_rready)
			rValid_d = 1'b0;
		if (s_axi_arvalid && !rValid_q)
		begin
			rValid_d = 1'b1;
			rResp_d = RESP_OKAY;
			rData_d = 32'h0000_0000;
			unique case (s_axi_araddr)
				OFS_P2_LATCH:  rData_d[7:0] = p2Lat_q;
				OFS_P2_MODE:   rData_d[7:0] = p2Mode_q;
				OFS_P2_PULLUP: rData_d[7:0] = p2Pu_q;
				OFS_ANA_SEL:   rData_d[3:0] = ana_q;
				OFS_P3_LATCH:  rData_d[7:0] = p3Lat_q;
				OFS_P3_MODE:   rData_d[7:0] = p3Mode_q;
				OFS_P2_PINS:   rData_d[7:0] = pinImage(p2Lat_q, p2Mode_q, p2PinIn);
				OFS_P3_PINS:   rData_d[7:0] = pinImage(p3Lat_q, p3Mode_q, p3PinIn);
				OFS_BITOP:     ;
				OFS_IRQ_STAT:  rData_d[1:0] = stat_q;
				OFS_IRQ_MASK:  rData_d[1:0] = mask_q;
				OFS_OPTION:    rData_d[POS_OPT_PORT] = optPort_q;
				default:       rResp_d = RESP_SLVERR;
			endcase
		end
		drv_d = irqPinLvl;
		irq_d = |(stat_d & ~mask_d);
	end

	// pin drive: analog pins lose port function, reset forces pull-downs
	always_comb
	begin
		p2Out_d = p2Lat_d;
		p2Oe_d = ~p2Mode_d & ~{4'h0, ana_d};
		p2PuO_d = p2Pu_d & ~{4'h0, ana_d};
		p2Pd_d = 8'h00;
		p3Out_d = p3Lat_d;
		p3Oe_d = ~p3Mode_d;
		p3Oe_d[POS_RST_PIN] = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			boot_q <= BOOT_HOLD; optPort_q <= 1'b0; coreRst_q <= 1'b1;
			awHave_q <= 1'b0; wHave_q <= 1'b0; bValid_q <= 1'b0; rValid_q <= 1'b0;
			awAddr_q <= 8'h00; wData_q <= 32'h0000_0000; rData_q <= 32'h0000_0000;
			bResp_q <= RESP_OKAY; rResp_q <= RESP_OKAY;
			p2Lat_q <= RST_LATCH; p2Mode_q <= RST_MODE; p2Pu_q <= RST_PU; ana_q <= RST_ANA;
			p3Lat_q <= RST_LATCH; p3Mode_q <= RST_MODE; stat_q <= 2'h0; mask_q <= RST_MASK;
			drv_q <= 2'h0; irq_q <= 1'b0;
			p2OutQ <= 8'h00; p2OeQ <= 8'h00; p2PuQ <= 8'h00; p3OutQ <= 8'h00; p3OeQ <= 8'h00;
			p2PdQ <= 8'((1 << POS_OSC_OUT) | (1 << POS_OSC_IN));
		end
		else
		begin
			boot_q <= boot_d; optPort_q <= optPort_d; coreRst_q <= coreRst_d;
			awHave_q <= awHave_d; wHave_q <= wHave_d; bValid_q <= bValid_d; rValid_q <= rValid_d;
			awAddr_q <= awAddr_d; wData_q <= wData_d; rData_q <= rData_d;
			bResp_q <= bResp_d; rResp_q <= rResp_d;
			p2Lat_q <= p2Lat_d; p2Mode_q <= p2Mode_d; p2Pu_q <= p2Pu_d; ana_q <= ana_d;
			p3Lat_q <= p3Lat_d; p3Mode_q <= p3Mode_d; stat_q <= stat_d; mask_q <= mask_d;
			drv_q <= drv_d; irq_q <= irq_d;
			p2OutQ <= p2Out_d; p2OeQ <= p2Oe_d; p2PuQ <= p2PuO_d; p3OutQ <= p3Out_d;
			p3OeQ <= p3Oe_d; p2PdQ <= p2Pd_d;
		end
	end

	// outputs from flops; arready also follows s_axi_arvalid
	assign s_axi_awready = awHave_q && wHave_q && !bValid_q;
	assign s_axi_wready  = awHave_q && wHave_q && !bValid_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = s_axi_arvalid && !rValid_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;
	assign p2PinOut = p2OutQ;
	assign p2PinOe = p2OeQ;
	assign p2PullUp = p2PuQ;
	assign p2PullDown = p2PdQ;
	assign analogRoute = ana_q;
	assign p3PinOut = p3OutQ;
	assign p3PinOe = p3OeQ;
	assign coreReset = coreRst_q;
	assign irqOut = irq_q;

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	pull_down_reset_a: assert property (@(posedge ref_clk) !rst_n |=> p2PullDown == 8'h0C)
		else $error("oscillator pins not pulled down in reset");
	reset_pin_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(boot_q == BOOT_FETCH && !port3_bit4_reset_shared) |=> coreReset)
		else $error("core left reset before option fetch");
	reset_pin_port_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(boot_q == BOOT_RUN && optPort_q) |=> boot_q == BOOT_RUN)
		else $error("port-mode pin caused reset");
	reset_pin_input_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		p3PinOe[POS_RST_PIN] == 1'b0)
		else $error("reset-shared pin driven");
	irq_edge_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!p2Mode_q[POS_IRQ_BIT1] && $changed(p2PinOut[POS_IRQ_BIT1])) |=> stat_q[0])
		else $error("irq flag not set on output change");
	// drive and pull-up follow the select in the same cycle, so check all four pins at once
	analog_oe_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		((p2PinOe[3:0] | p2PullUp[3:0]) & ana_q) == 4'h0)
		else $error("analog pin still driven");
	whole_port_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wrFire && awAddr_q == OFS_P2_LATCH) |=> p2Lat_q == $past(wData_q[7:0]))
		else $error("byte write lost");
	bit_rmw_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wrFire && awAddr_q == OFS_BITOP && !wData_q[POS_BIT_PORT])
		|=> p2Lat_q == $past(bitIf.merged)
		&& p2Lat_q[$past(wData_q[2:0])] == $past(wData_q[POS_BIT_VAL]))
		else $error("bit write not merged");
	irq_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		irqOut == |(stat_q & ~mask_q))
		else $error("irq output wrong");
	cov_bitop_c: cover property (@(posedge ref_clk) wrFire && awAddr_q == OFS_BITOP);
	cov_irq_c: cover property (@(posedge ref_clk) irqOut);
	cov_run_c: cover property (@(posedge ref_clk) boot_q == BOOT_RUN);
endmodule

// ==== pkg/ppc_pkg.sv ====
// package: register map, field positions, reset values and states of the port pin block
package ppc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_P2_LATCH  = 8'h00;
	localparam logic [7:0] OFS_P2_MODE   = 8'h04;
	localparam logic [7:0] OFS_P2_PULLUP = 8'h08;
	localparam logic [7:0] OFS_ANA_SEL   = 8'h0C;
	localparam logic [7:0] OFS_P3_LATCH  = 8'h10;
	localparam logic [7:0] OFS_P3_MODE   = 8'h14;
	localparam logic [7:0] OFS_P2_PINS   = 8'h18;
	localparam logic [7:0] OFS_P3_PINS   = 8'h1C;
	localparam logic [7:0] OFS_BITOP     = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h24;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h28;
	localparam logic [7:0] OFS_OPTION    = 8'h2C;
	// reset values
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_MODE  = 8'hFF;
	localparam logic [7:0] RST_PU    = 8'h00;
	localparam logic [3:0] RST_ANA   = 4'hF;
	localparam logic [1:0] RST_MASK  = 2'h3;
	// field positions
	localparam int POS_IRQ_BIT1 = 1;
	localparam int POS_IRQ_BIT2 = 2;
	localparam int POS_OSC_OUT  = 2;
	localparam int POS_OSC_IN   = 3;
	localparam int POS_RST_PIN  = 4;
	localparam int POS_OPT_PORT = 0;
	localparam int POS_BIT_VAL  = 3;
	localparam int POS_BIT_PORT = 4;
	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// boot sequence states
	typedef enum logic [2:0]
	{
		BOOT_HOLD  = 3'b001,
		BOOT_FETCH = 3'b010,
		BOOT_RUN   = 3'b100
	} ppc_boot_t;
endpackage

// ==== pkg/ppc_bit_if.sv ====
// interface: single-bit read-modify-write request between bus slave and the merge unit
`timescale 1ns/1ps
interface ppc_bit_if;
	logic [7:0] pinLevels;
	logic [2:0] bitSel;
	logic       bitVal;
	logic [7:0] merged;
	modport user (output pinLevels, output bitSel, output bitVal, input merged);
	modport unit (input pinLevels, input bitSel, input bitVal, output merged);
endinterface

// ==== src/ppc_bit_merge.sv ====
// single-bit merge: replaces one bit of the sampled 8-bit pin image
`timescale 1ns/1ps
module ppc_bit_merge
(
	// request and result
	ppc_bit_if.unit bitIf
);
	// the whole port is read back, so input-mode bits copy the pin level into the latch
	always_comb
	begin
		bitIf.merged = bitIf.pinLevels;
		bitIf.merged[bitIf.bitSel] = bitIf.bitVal;
	end
endmodule

// ==== test/ppc_pin_model.sv ====
// board-side pin model: resolves port 2 and port 3 pin levels
`timescale 1ns/1ps
module ppc_pin_model
(
	// clock
	input  wire logic       ref_clk,
	// design drive
	input  wire logic [7:0] p2PinOut,
	input  wire logic [7:0] p2PinOe,
	input  wire logic [7:0] p2PullUp,
	input  wire logic [7:0] p2PullDown,
	input  wire logic [7:0] p3PinOut,
	input  wire logic [7:0] p3PinOe,
	// board drive
	input  wire logic [7:0] extLvl,
	input  wire logic [7:0] extEn,
	input  wire logic       rstPinLvl,
	// pin levels
	output logic [7:0]      p2PinIn,
	output logic [7:0]      p3PinIn,
	output logic            port3_bit4_reset_shared
);
	logic [7:0] floatQ = 8'h55;

	// undriven lines wander so a stale level never passes for a driven one
	always @(posedge ref_clk)
		floatQ <= ~floatQ;

	// priority on port 2: own drive, board drive, pull-up, pull-down, float; port 3: own drive, float, bit 4 the reset pin
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			p2PinIn[i] = p2PinOe[i] ? p2PinOut[i] : extEn[i] ? extLvl[i] :
				p2PullUp[i] ? 1'b1 : p2PullDown[i] ? 1'b0 : floatQ[i];
			p3PinIn[i] = p3PinOe[i] ? p3PinOut[i] : floatQ[i];
		end
		p3PinIn[4] = rstPinLvl;
		port3_bit4_reset_shared = rstPinLvl;
	end
endmodule

// ==== test/ppc_port_ctrl_test.sv ====
// testbench: register-level tests of the port pin block
`timescale 1ns/1ps
module ppc_port_ctrl_test
	import ppc_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, bResp, rResp;
	logic [31:0] s_axi_rdata, v;
	logic        optPortMode = 1'b0;
	logic        rstPinLvl = 1'b1;
	logic        port3_bit4_reset_shared, coreReset, irqOut;
	logic [7:0]  extLvl = 8'h00;
	logic [7:0]  extEn = 8'h00;
	logic [7:0]  p2PinIn, p2PinOut, p2PinOe, p2PullUp, p2PullDown, p3PinIn, p3PinOut, p3PinOe;
	logic [3:0]  analogRoute;
	int          failCount = 0;
	int          checksDone = 0;
	int          cycles = 0;

	ppc_port_ctrl u_dut (.*);
	ppc_pin_model u_pins (.*);

	// clock and hang guard; the whole run needs well under 4000 cycles
	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			failCount++;
			wrap_up;
		end
	end

	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			failCount++;
			$display("BAD t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask

	// write: address and data offered together, held until taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(posedge ref_clk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b1;
		do @(posedge ref_clk); while (!s_axi_bvalid);
		bResp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge ref_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		rResp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task rdChk(input logic [7:0] a, input logic [31:0] exp);
		rd(a, v);
		chk(v, exp);
	endtask

	// bounded wait for the core reset to reach a level
	task waitCore(input logic lvl);
		for (int i = 0; i < 20 && coreReset !== lvl; i++)
			@(posedge ref_clk);
		chk(coreReset, lvl);
	endtask

	task boot(input logic portMode, input logic pin);
		optPortMode <= portMode;
		rstPinLvl <= pin;
		rst_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		chk({p2PullDown, analogRoute, coreReset, p2PinIn[3:2]}, {8'h0C, 4'hF, 1'b1, 2'h0});
		rst_n <= 1'b1;
		@(posedge ref_clk);
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		@(posedge ref_clk);
		// port mode: a low pin must not reset the core
		boot(1'b1, 1'b1);
		waitCore(1'b0);
		rdChk(OFS_OPTION, 32'h1);
		rstPinLvl <= 1'b0;
		repeat (10) @(posedge ref_clk);
		chk(coreReset, 1'b0);
		rd(OFS_P3_PINS, v);
		chk(v[POS_RST_PIN], 1'b0);
		$display("port mode boot done");
		// reset mode, pin low before the option fetch holds the core
		boot(1'b0, 1'b0);
		repeat (20) @(posedge ref_clk);
		chk(coreReset, 1'b1);
		rstPinLvl <= 1'b1;
		waitCore(1'b0);
		rdChk(OFS_OPTION, 32'h0);
		rstPinLvl <= 1'b0;
		waitCore(1'b1);
		rstPinLvl <= 1'b1;
		waitCore(1'b0);
		$display("reset mode boot done");
		// analog select; drive stays off on analog pins, pull-ups set only on the other pins
		rdChk(OFS_ANA_SEL, 32'h0F);
		wr(OFS_ANA_SEL, 32'h05);
		wr(OFS_P2_MODE, 32'h00);
		wr(OFS_P2_PULLUP, 32'h0A);
		@(posedge ref_clk);
		chk({analogRoute, p2PinOe, p2PullUp}, {4'h5, 8'hFA, 8'h0A});
		$display("analog select done");
		// single-bit ops on a mixed port pick up the input pin levels
		wr(OFS_ANA_SEL, 32'h00);
		wr(OFS_P2_MODE, 32'hF0);
		extLvl <= 8'hA0;
		extEn <= 8'hF0;
		wr(OFS_P2_LATCH, 32'h00);
		wr(OFS_BITOP, 32'h08);
		rdChk(OFS_P2_LATCH, 32'hA1);
		wr(OFS_BITOP, 32'h05);
		rdChk(OFS_P2_LATCH, 32'h81);
		wr(OFS_P3_MODE, 32'h10);
		wr(OFS_P3_LATCH, 32'h00);
		wr(OFS_BITOP, 32'h1A);
		rdChk(OFS_P3_LATCH, 32'h14);
		wr(OFS_P3_MODE, 32'h00);
		@(posedge ref_clk);
		chk({p3PinOut, p3PinOe}, {8'h14, 8'hEF});
		$display("bit operations done");
		// output level changes on the irq pins, masked first
		wr(OFS_IRQ_MASK, 32'h3);
		wr(OFS_P2_MODE, 32'hFD);
		wr(OFS_P3_MODE, 32'hFB);
		wr(OFS_IRQ_STAT, 32'h3);
		wr(OFS_P2_LATCH, 32'h02);
		wr(OFS_P3_LATCH, 32'h00);
		rdChk(OFS_IRQ_STAT, 32'h3);
		chk({p2PinOut[POS_IRQ_BIT1], p3PinOut[POS_IRQ_BIT2]}, 2'b10);
		chk(irqOut, 1'b0);
		wr(OFS_IRQ_MASK, 32'h2);
		repeat (2) @(posedge ref_clk);
		chk(irqOut, 1'b1);
		wr(OFS_IRQ_STAT, 32'h1);
		rdChk(OFS_IRQ_STAT, 32'h2);
		chk(irqOut, 1'b0);
		$display("interrupt pins done");
		// unmapped and read-only places
		rd(8'h30, v);
		chk(rResp, RESP_SLVERR);
		wr(OFS_P2_PINS, 32'hFF);
		chk(bResp, RESP_OKAY);
		$display("bus errors done");
		wrap_up;
	end
endmodule
